// ===== core/adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;
    // ************************************************
    // Register byte addresses
    // ************************************************
    localparam logic [11:0] ADDR_CTRL0 = 12'hea0;
    localparam logic [11:0] ADDR_CTRL1 = 12'hea4;
    localparam logic [11:0] ADDR_RES_HIGH = 12'hea8;
    localparam logic [11:0] ADDR_RES_LOW = 12'heac;
    localparam logic [11:0] ADDR_PIN_CFG0 = 12'heb0;
    localparam logic [11:0] ADDR_PIN_CFG1 = 12'heb4;
    localparam logic [11:0] ADDR_TRIG_SEL = 12'heb8;
    localparam logic [11:0] ADDR_STATUS = 12'hebc;
    // ************************************************
    // Fields, masks and reset values
    // ************************************************
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_MODE12_BIT = 1;
    localparam logic [7:0] PIN_CFG1_MASK = 8'h9f;
    localparam logic [7:0] TRIG_SEL_MASK = 8'h03;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] TRIG_COMPARE = 2'h0;
    localparam logic [1:0] TRIG_CHARGE = 2'h1;
    localparam logic [1:0] TRIG_TIMER = 2'h2;
    localparam logic [1:0] TRIG_ALARM = 2'h3;
    localparam logic [2:0] CLK_SEL_RC = 3'h3;
    // ************************************************
    // Timing counts
    // ************************************************
    localparam logic [7:0] INSTR_CYCLE_CLKS = 8'h04;
    localparam logic [4:0] HOLD_TADS = 5'h02;
    localparam logic [4:0] CONV_TADS_10 = 5'h0b;
    localparam logic [4:0] CONV_TADS_12 = 5'h0d;
    // ************************************************
    // Register layouts and states
    // ************************************************
    typedef struct packed {
        logic [1:0] vref_sel;
        logic [3:0] channel_sel;
        logic go;
        logic converter_on;
    } ctrl0_t;
    typedef struct packed {
        logic result_justify;
        logic offset_cal_request;
        logic [2:0] acq_time_sel;
        logic [2:0] conv_clock_sel;
    } ctrl1_t;
    typedef enum logic [2:0] {
        ST_OFF, ST_SAMPLE, ST_DELAY, ST_ACQ, ST_CONV, ST_HOLD
    } seq_state_t;
endpackage
`default_nettype wire

// ===== core/adc_conversion_sequencer.sv
// How it works
// - Clearing go mid-conversion aborts it; result bytes keep their old value.
// - After completion or abort, wait two conversion periods before next acquisition.
// - After that wait, sampling of the selected channel resumes by itself.
// - Acquisition code 000 delays conversion start by one instruction cycle.
// - Acquisition code 010 samples four conversion periods, then converts.
// - Trigger select: 00 compare, 01 charge-time, 10 timer, 11 alarm.
// - A selected trigger pulse sets go and starts acquisition.
// - With the converter off, triggers are ignored and go is untouched.
// - A compare trigger always clears its timer, even with converter off.
// - Calibration request makes the next go run an offset calibration.
// - On completion the done flag sets and go clears, unless a selected trigger pulse arrives in the same cycle, which keeps go set.
// - Conversion lasts 11 periods in 10-bit mode, 13 in 12-bit mode.
// - Clock code picks divide 2,4,8,16,32,64 or the RC clock.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_sequencer #(
    parameter int RES_W = 12
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trig_compare,
    input wire logic trig_charge,
    input wire logic trig_timer,
    input wire logic trig_alarm,
    input wire logic rc_clk,
    input wire logic [RES_W-1:0] core_result,
    output logic compare_timer_clear,
    output logic sample_en,
    output logic convert_en,
    output logic cal_en,
    output logic tad_tick,
    output adc_seq_pkg::ctrl0_t ctrl0,
    output adc_seq_pkg::ctrl1_t ctrl1,
    output logic [15:0] pin_analog_sel
);
    import adc_seq_pkg::*;

    // Only a 12-bit core result fits the result byte layout
    if (RES_W != 12) begin : g_res_w_check
        $error("RES_W must be 12");
    end

    // ************************************************
    // Helpers
    // ************************************************
    // Oscillator divide for a clock code
    function automatic logic [6:0] div_of(input logic [2:0] code);
        unique case (code)
            3'h0: div_of = 7'h02;
            3'h4: div_of = 7'h04;
            3'h1: div_of = 7'h08;
            3'h5: div_of = 7'h10;
            3'h2: div_of = 7'h20;
            3'h6: div_of = 7'h40;
            default: div_of = 7'h02;
        endcase
    endfunction

    // Acquisition length in conversion periods
    function automatic logic [4:0] acq_tads(input logic [2:0] code);
        unique case (code)
            3'h0: acq_tads = 5'h00;
            3'h1: acq_tads = 5'h02;
            3'h2: acq_tads = 5'h04;
            3'h3: acq_tads = 5'h06;
            3'h4: acq_tads = 5'h08;
            3'h5: acq_tads = 5'h0c;
            3'h6: acq_tads = 5'h10;
            3'h7: acq_tads = 5'h14;
        endcase
    endfunction

    // ************************************************
    // State
    // ************************************************
    logic [7:0] res_high_reg, res_low_reg, pin_cfg0_reg, pin_cfg1_reg, trig_sel_reg;
    logic done_flag_reg, mode12_reg, cal_run_reg, tick_reg;
    logic [RES_W-1:0] offset_reg;
    logic [6:0] div_cnt_reg;
    logic [2:0] rc_sync_reg;
    logic rc_level_reg;
    logic [7:0] cnt_reg;
    seq_state_t state_reg;

    logic wr_en, rd_en, hit, trig_sel, done_now, abort_now;
    logic [4:0] conv_tads;
    logic [RES_W-1:0] corrected;
    logic [15:0] justified;

    assign wr_en = ce && psel && penable && pready && pwrite;
    assign rd_en = ce && psel && penable && !pready;
    assign hit = paddr inside {ADDR_CTRL0, ADDR_CTRL1, ADDR_RES_HIGH, ADDR_RES_LOW,
                               ADDR_PIN_CFG0, ADDR_PIN_CFG1, ADDR_TRIG_SEL, ADDR_STATUS};
    assign conv_tads = mode12_reg ? CONV_TADS_12 : CONV_TADS_10;

    // Selected hardware trigger
    always_comb begin
        unique case (trig_sel_reg[1:0])
            TRIG_COMPARE: trig_sel = trig_compare;
            TRIG_CHARGE: trig_sel = trig_charge;
            TRIG_TIMER: trig_sel = trig_timer;
            TRIG_ALARM: trig_sel = trig_alarm;
        endcase
    end

    // Completion and abort events
    assign done_now = ce && state_reg == ST_CONV && ctrl0.go && tick_reg
                      && cnt_reg == 8'(conv_tads - 5'h01);
    assign abort_now = ce && !ctrl0.go && ctrl0.converter_on
                       && state_reg inside {ST_DELAY, ST_ACQ, ST_CONV};

    // Offset correction and result placement
    assign corrected = (core_result > offset_reg) ? core_result - offset_reg : '0;
    always_comb begin
        if (mode12_reg) begin
            justified = ctrl1.result_justify ? {4'h0, corrected} : {corrected, 4'h0};
        end else begin
            justified = ctrl1.result_justify ? {6'h00, corrected[11:2]}
                                             : {corrected[11:2], 6'h00};
        end
    end

    // ************************************************
    // APB slave
    // ************************************************
    // One wait state, read data captured with ready
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            pready <= rd_en;
            pslverr <= rd_en && !hit;
            if (rd_en) begin
                unique case (paddr)
                    ADDR_CTRL0: prdata <= {24'h0, ctrl0};
                    ADDR_CTRL1: prdata <= {24'h0, ctrl1};
                    ADDR_RES_HIGH: prdata <= {24'h0, res_high_reg};
                    ADDR_RES_LOW: prdata <= {24'h0, res_low_reg};
                    ADDR_PIN_CFG0: prdata <= {24'h0, pin_cfg0_reg};
                    ADDR_PIN_CFG1: prdata <= {24'h0, pin_cfg1_reg};
                    ADDR_TRIG_SEL: prdata <= {24'h0, trig_sel_reg};
                    ADDR_STATUS: prdata <= {30'h0, mode12_reg, done_flag_reg};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Plain configuration registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl1 <= REG_RESET;
            pin_cfg0_reg <= REG_RESET;
            pin_cfg1_reg <= REG_RESET;
            trig_sel_reg <= REG_RESET;
            mode12_reg <= 1'b0;
        end else if (wr_en) begin
            if (paddr == ADDR_CTRL1) ctrl1 <= pwdata[7:0];
            if (paddr == ADDR_PIN_CFG0) pin_cfg0_reg <= pwdata[7:0];
            if (paddr == ADDR_PIN_CFG1) pin_cfg1_reg <= pwdata[7:0] & PIN_CFG1_MASK;
            if (paddr == ADDR_TRIG_SEL) trig_sel_reg <= pwdata[7:0] & TRIG_SEL_MASK;
            if (paddr == ADDR_STATUS) mode12_reg <= pwdata[STAT_MODE12_BIT];
        end
    end

    // Control 0: go is set by software, trigger; cleared by software, completion
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl0 <= REG_RESET;
        end else if (ce) begin
            if (wr_en && paddr == ADDR_CTRL0) begin
                ctrl0.vref_sel <= pwdata[7:6];
                ctrl0.channel_sel <= pwdata[5:2];
                ctrl0.converter_on <= pwdata[0];
                ctrl0.go <= pwdata[1] && ctrl0.converter_on;
            end
            if (done_now) begin
                ctrl0.go <= 1'b0;
            end
            if (ctrl0.converter_on && trig_sel) begin
                ctrl0.go <= 1'b1;
            end
        end
    end

    // Result bytes and stored offset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            res_high_reg <= REG_RESET;
            res_low_reg <= REG_RESET;
            offset_reg <= '0;
        end else if (done_now && cal_run_reg) begin
            offset_reg <= core_result;
        end else if (done_now) begin
            res_high_reg <= justified[15:8];
            res_low_reg <= justified[7:0];
        end else if (wr_en) begin
            if (paddr == ADDR_RES_HIGH) res_high_reg <= pwdata[7:0];
            if (paddr == ADDR_RES_LOW) res_low_reg <= pwdata[7:0];
        end
    end

    // Done flag, write one to clear, completion wins
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            done_flag_reg <= 1'b0;
        end else if (done_now) begin
            done_flag_reg <= 1'b1;
        end else if (wr_en && paddr == ADDR_STATUS && pwdata[STAT_DONE_BIT]) begin
            done_flag_reg <= 1'b0;
        end
    end

    // ************************************************
    // Conversion clock
    // ************************************************
    // RC clock synchroniser and filter
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rc_sync_reg <= 3'h0;
            rc_level_reg <= 1'b0;
        end else if (ce) begin
            rc_sync_reg <= {rc_sync_reg[1:0], rc_clk};
            if (rc_sync_reg[1] == rc_sync_reg[2]) rc_level_reg <= rc_sync_reg[2];
        end
    end

    // Period tick from divider or RC rising edge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_reg <= 7'h00;
            tick_reg <= 1'b0;
        end else if (ce) begin
            if (ctrl1.conv_clock_sel == CLK_SEL_RC) begin
                div_cnt_reg <= 7'h00;
                tick_reg <= rc_sync_reg[1] && rc_sync_reg[2] && !rc_level_reg;
            end else if (div_cnt_reg >= div_of(ctrl1.conv_clock_sel) - 7'h01) begin
                div_cnt_reg <= 7'h00;
                tick_reg <= 1'b1;
            end else begin
                div_cnt_reg <= div_cnt_reg + 7'h01;
                tick_reg <= 1'b0;
            end
        end
    end

    // ************************************************
    // Sequencer
    // ************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_OFF;
            cnt_reg <= 8'h00;
            cal_run_reg <= 1'b0;
        end else if (ce) begin
            if (!ctrl0.converter_on) begin
                state_reg <= ST_OFF;
                cnt_reg <= 8'h00;
            end else if (abort_now) begin
                state_reg <= ST_HOLD;
                cnt_reg <= 8'h00;
            end else begin
                unique case (state_reg)
                    ST_OFF: state_reg <= ST_SAMPLE;
                    ST_SAMPLE: begin
                        cnt_reg <= 8'h00;
                        cal_run_reg <= ctrl1.offset_cal_request;
                        if (ctrl0.go && acq_tads(ctrl1.acq_time_sel) == 5'h00) begin
                            state_reg <= ST_DELAY;
                        end else if (ctrl0.go) begin
                            state_reg <= ST_ACQ;
                        end
                    end
                    ST_DELAY: begin
                        cnt_reg <= cnt_reg + 8'h01;
                        if (cnt_reg == INSTR_CYCLE_CLKS - 8'h01) begin
                            state_reg <= ST_CONV;
                            cnt_reg <= 8'h00;
                        end
                    end
                    ST_ACQ: if (tick_reg) begin
                        cnt_reg <= cnt_reg + 8'h01;
                        if (cnt_reg == 8'(acq_tads(ctrl1.acq_time_sel) - 5'h01)) begin
                            state_reg <= ST_CONV;
                            cnt_reg <= 8'h00;
                        end
                    end
                    ST_CONV: if (tick_reg) begin
                        cnt_reg <= cnt_reg + 8'h01;
                        if (done_now) begin
                            state_reg <= ST_HOLD;
                            cnt_reg <= 8'h00;
                        end
                    end
                    ST_HOLD: if (tick_reg) begin
                        cnt_reg <= cnt_reg + 8'h01;
                        if (cnt_reg == 8'(HOLD_TADS - 5'h01)) begin
                            state_reg <= ST_SAMPLE;
                        end
                    end
                endcase
            end
        end
    end

    // ************************************************
    // Outputs to the analog core and timers
    // ************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sample_en <= 1'b0;
            convert_en <= 1'b0;
            cal_en <= 1'b0;
            tad_tick <= 1'b0;
            compare_timer_clear <= 1'b0;
            pin_analog_sel <= 16'h0000;
        end else if (ce) begin
            sample_en <= state_reg inside {ST_SAMPLE, ST_DELAY, ST_ACQ};
            convert_en <= state_reg == ST_CONV;
            cal_en <= state_reg == ST_CONV && cal_run_reg;
            tad_tick <= tick_reg;
            compare_timer_clear <= trig_compare;
            pin_analog_sel <= {pin_cfg1_reg, pin_cfg0_reg};
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    logic [4:0] conv_ticks;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            conv_ticks <= 5'h00;
        end else if (ce && state_reg != ST_CONV) begin
            conv_ticks <= 5'h00;
        end else if (ce && tick_reg) begin
            conv_ticks <= conv_ticks + 5'h01;
        end
    end

    a_abort_keeps: assert property (@(posedge mclk) disable iff (!resetn)
        abort_now && !wr_en |=> $stable(res_high_reg) && $stable(res_low_reg)
        && state_reg == ST_HOLD) else $error("abort changed result");
    a_hold_two: assert property (@(posedge mclk) disable iff (!resetn)
        ce && state_reg == ST_HOLD && ctrl0.converter_on && cnt_reg == 8'h00 && tick_reg
        |=> state_reg == ST_HOLD) else $error("hold too short");
    a_resume_sample: assert property (@(posedge mclk) disable iff (!resetn)
        ce && state_reg == ST_HOLD && ctrl0.converter_on && tick_reg && cnt_reg == 8'h01
        |=> state_reg == ST_SAMPLE) else $error("sampling not resumed");
    a_delay_one: assert property (@(posedge mclk) disable iff (!resetn)
        ce && state_reg == ST_SAMPLE && ctrl0.go && ctrl0.converter_on
        && ctrl1.acq_time_sel == 3'h0 |=> state_reg == ST_DELAY)
        else $error("no start delay");
    a_acq_four: assert property (@(posedge mclk) disable iff (!resetn)
        ce && state_reg == ST_ACQ && ctrl0.go && ctrl0.converter_on && tick_reg
        && ctrl1.acq_time_sel == 3'h2 && cnt_reg < 8'h03 |=> state_reg == ST_ACQ)
        else $error("acquisition too short");
    a_trig_ignored: assert property (@(posedge mclk) disable iff (!resetn)
        ce && !ctrl0.converter_on && !wr_en |=> !ctrl0.go || $past(ctrl0.go))
        else $error("trigger set go while off");
    a_trig_sets_go: assert property (@(posedge mclk) disable iff (!resetn)
        ce && ctrl0.converter_on && trig_sel |=> ctrl0.go) else $error("trigger lost");
    a_timer_clear: assert property (@(posedge mclk) disable iff (!resetn)
        ce && trig_compare |=> compare_timer_clear) else $error("timer not cleared");
    a_done_flag: assert property (@(posedge mclk) disable iff (!resetn)
        done_now && !trig_sel |=> !ctrl0.go && done_flag_reg) else $error("done missing");
    a_conv_len: assert property (@(posedge mclk) disable iff (!resetn)
        done_now |-> conv_ticks + 5'h01 == conv_tads) else $error("wrong conversion length");
endmodule
`default_nettype wire

// ===== tb/adc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module adc_core_model #(
    parameter logic [11:0] RAW = 12'h5a3,
    parameter logic [11:0] OFFSET = 12'h010
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic fire,
    input wire logic [1:0] src,
    input wire logic [3:0] cmp_mode,
    input wire logic chg_en,
    input wire logic convert_en,
    input wire logic cal_en,
    output logic trig_compare,
    output logic trig_charge,
    output logic trig_timer,
    output logic trig_alarm,
    output logic rc_clk,
    output logic [11:0] core_result
);
    logic [2:0] rc_cnt;
    logic busy_d;
    logic cal_d;
    // One-cycle trigger pulse from the commanded source
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {trig_compare, trig_charge, trig_timer, trig_alarm} <= 4'h0;
        end else begin
            trig_compare <= fire && src == 2'h0 && cmp_mode == 4'hb;
            trig_charge <= fire && src == 2'h1 && chg_en;
            trig_timer <= fire && src == 2'h2;
            trig_alarm <= fire && src == 2'h3;
        end
    end
    // Free-running RC oscillator and result hold tracking
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {rc_cnt, busy_d, cal_d} <= 5'h00;
        end else begin
            rc_cnt <= rc_cnt + 3'h1;
            busy_d <= convert_en;
            cal_d <= cal_en;
        end
    end
    assign rc_clk = rc_cnt[2];
    // Outside a run the result lines show the inverse, not a held value
    assign core_result = (cal_en || cal_d) ? OFFSET : ((convert_en || busy_d) ? RAW : ~RAW);
endmodule
`default_nettype wire

// ===== tb/adc_conversion_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_sequencer_bench;
    import adc_seq_pkg::*;
    logic mclk, resetn, psel, penable, pwrite, pready, pslverr, err, fire, chg_en, m12;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] src;
    logic [3:0] cmp_mode;
    logic t_cmp, t_chg, t_tim, t_alm, rc_clk, clr, sample_en, convert_en, cal_en, cal_seen;
    logic [11:0] core_result;
    ctrl0_t ctrl0;
    ctrl1_t ctrl1;
    logic [15:0] pin_sel;
    int fails, checks_done, cyc, clr_cnt, n, tads, per;
    logic [7:0] c1;
    adc_conversion_sequencer uut (.mclk(mclk), .resetn(resetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trig_compare(t_cmp), .trig_charge(t_chg),
        .trig_timer(t_tim), .trig_alarm(t_alm), .rc_clk(rc_clk), .core_result(core_result),
        .compare_timer_clear(clr), .sample_en(sample_en), .convert_en(convert_en),
        .cal_en(cal_en), .tad_tick(), .ctrl0(ctrl0), .ctrl1(ctrl1), .pin_analog_sel(pin_sel));
    adc_core_model partner (.mclk(mclk), .resetn(resetn), .fire(fire), .src(src),
        .cmp_mode(cmp_mode), .chg_en(chg_en), .convert_en(convert_en), .cal_en(cal_en),
        .trig_compare(t_cmp), .trig_charge(t_chg), .trig_timer(t_tim), .trig_alarm(t_alm),
        .rc_clk(rc_clk), .core_result(core_result));
    // ****
    // Tasks
    // ****
    task automatic results;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic span(input int v, input int lo, input int hi);
        check({31'h0, v >= lo && v <= hi}, 32'h1);
    endtask
    // APB transfer, held until pready is sampled high, then one idle edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    // Cycles until convert_en, sample_en or go shows the given level
    task automatic wait_for(input int sel, input logic lvl, output int cnt);
        logic s;
        cnt = 0;
        do begin
            @(posedge mclk);
            cnt++;
            s = sel == 0 ? convert_en : (sel == 1 ? sample_en : ctrl0.go);
        end while (s !== lvl);
    endtask
    task automatic pulse(input logic [1:0] s);
        src <= s;
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
    endtask
    // ****
    // Clock, watchdog and event counters
    // ****
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (clr === 1'b1) clr_cnt++;
        if (cal_en === 1'b1) cal_seen = 1'b1;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end
    // ****
    // Test sequence
    // ****
    initial begin
        {psel, penable, pwrite, fire, chg_en, resetn, cal_seen} = 7'h00;
        {paddr, pwdata, src} = 46'h0;
        cmp_mode = 4'hb;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            apb(1'b0, ADDR_CTRL0 + 12'(a * 4), 8'h00);
            check(rd, {24'h0, REG_RESET});
        end
        apb(1'b0, 12'h000, 8'h00);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, ADDR_TRIG_SEL, 8'hff);
        apb(1'b0, ADDR_TRIG_SEL, 8'h00);
        check(rd, 32'h3);
        apb(1'b1, ADDR_PIN_CFG0, 8'h5a);
        apb(1'b1, ADDR_PIN_CFG1, 8'hff);
        @(posedge mclk);
        check({16'h0, pin_sel}, 32'h9f5a);
        apb(1'b1, ADDR_TRIG_SEL, 8'h00);
        pulse(2'h0);
        repeat (3) @(posedge mclk);
        check({24'h0, ctrl0}, 32'h0);
        check(clr_cnt, 1);
        apb(1'b1, ADDR_CTRL0, 8'h01);
        apb(1'b1, ADDR_STATUS, 8'h02);
        apb(1'b1, ADDR_CTRL1, 8'hc0);
        apb(1'b1, ADDR_CTRL0, 8'h03);
        wait_for(2, 1'b0, n);
        check({31'h0, cal_seen}, 32'h1);
        chg_en <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            m12 = s < 2;
            tads = m12 ? 13 : 11;
            per = s == 2 ? 8 : 2;
            c1 = s == 2 ? 8'h83 : (s == 3 ? 8'h00 : 8'h80);
            apb(1'b1, ADDR_CTRL1, c1);
            apb(1'b1, ADDR_STATUS, {6'h0, m12, 1'b1});
            apb(1'b1, ADDR_TRIG_SEL, 8'(s));
            wait_for(1, 1'b1, n);
            pulse(2'(s));
            wait_for(0, 1'b1, n);
            wait_for(0, 1'b0, n);
            span(n, per * tads - per, per * tads + per);
            wait_for(2, 1'b0, n);
            check({24'h0, ctrl0}, 32'h1);
            apb(1'b0, ADDR_STATUS, 8'h00);
            check(rd, {30'h0, m12, 1'b1});
            apb(1'b0, ADDR_RES_HIGH, 8'h00);
            check(rd, m12 ? 32'h05 : (s == 2 ? 32'h01 : 32'h59));
            apb(1'b0, ADDR_RES_LOW, 8'h00);
            check(rd, m12 ? 32'h93 : (s == 2 ? 32'h64 : 32'h00));
        end
        check(clr_cnt, 2);
        apb(1'b1, ADDR_STATUS, 8'h03);
        apb(1'b1, ADDR_RES_HIGH, 8'hab);
        apb(1'b1, ADDR_RES_LOW, 8'hcd);
        wait_for(1, 1'b1, n);
        apb(1'b1, ADDR_CTRL0, 8'h03);
        wait_for(0, 1'b1, n);
        span(n, 4, 9);
        apb(1'b1, ADDR_CTRL0, 8'h01);
        wait_for(1, 1'b1, n);
        span(n, 3, 7);
        apb(1'b0, ADDR_RES_HIGH, 8'h00);
        check(rd, 32'hab);
        apb(1'b0, ADDR_RES_LOW, 8'h00);
        check(rd, 32'hcd);
        apb(1'b1, ADDR_CTRL1, 8'h90);
        apb(1'b1, ADDR_CTRL0, 8'h03);
        wait_for(0, 1'b1, n);
        span(n, 7, 11);
        wait_for(2, 1'b0, n);
        apb(1'b0, ADDR_RES_LOW, 8'h00);
        check(rd, 32'h93);
        results();
    end
endmodule
`default_nettype wire
